/* verilog/fpfc_pkg.sv */
`default_nettype none
package fpfc_pkg;

  // ----------------------------------------------------------------
  // clock
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 50;
  localparam int CLK_PERIOD_NS = 20;

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  localparam int               PER_W           = 10;
  localparam int               OSC_FREQ_KHZ    = 65;
  localparam logic [PER_W-1:0] PERIOD_CYC      = PER_W'(CLK_MHZ * 1000 / OSC_FREQ_KHZ);
  // jitter span is a plain choice: half the triangle swing, in cycles
  localparam logic [PER_W-1:0] JITTER_SPAN_CYC = 10'h018;
  localparam int               MAX_DUTY_PCT    = 80;
  localparam int               PCT_FULL        = 100;

  // ----------------------------------------------------------------
  // current sense path
  // ----------------------------------------------------------------
  localparam int FB_DIVIDE_RATIO    = 5;
  localparam int PEAK_LIMIT_FB_MV   = 3500;
  localparam int LEB_NS             = 250;
  localparam int LEB_CYC            = (LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_W              = 5;
  // slope compensation, 65 kHz build, in microvolt per microsecond
  localparam int SLOPE_UV_PER_US    = 32500;
  localparam int SLOPE_UV_PER_CYC   = SLOPE_UV_PER_US * CLK_PERIOD_NS / 1000;
  localparam int SLOPE_W            = 20;

  // ----------------------------------------------------------------
  // soft-start ramp: code full scale stands for the peak limit level
  // ----------------------------------------------------------------
  localparam int              SS_W        = 10;
  localparam logic [SS_W-1:0] SS_CODE_MAX = 10'h3FF;
  localparam int              SS_TIME_US  = 4000;
  localparam int              SS_CYC      = SS_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // timers, in cycles of the internal clock
  // ----------------------------------------------------------------
  localparam int TMR_W           = 32;
  localparam int FAULT_TIME_US   = 100000;
  localparam int FAULT_CYC       = FAULT_TIME_US * CLK_MHZ;
  localparam int AUTOREC_TIME_US = 1000000;
  localparam int AUTOREC_CYC     = AUTOREC_TIME_US * CLK_MHZ;
  localparam int WD_TIME_US      = 32000;
  localparam int WD_CYC          = WD_TIME_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // controller state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_PROT = 3'b100
  } fpfc_state_t;

endpackage : fpfc_pkg
`default_nettype wire

/* verilog/fpfc_jitter_osc.sv */
`timescale 1ns/1ps
`default_nettype none
module fpfc_jitter_osc
  import fpfc_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // control
  input  wire logic i_jitter_hold,
  // timing outputs
  output logic      o_period_start,
  output logic      o_max_duty
);

  // ----------------------------------------------------------------
  // period length from the triangle offset
  // ----------------------------------------------------------------
  logic [PER_W-1:0]   cnt_ff;
  logic [PER_W-1:0]   jit_ff;
  logic               jit_up_ff;
  logic [PER_W-1:0]   period_len;
  logic [PER_W+6:0]   duty_prod;
  logic [PER_W-1:0]   max_on;
  logic               wrap;
  logic [PER_W-1:0]   nxt_jit;
  logic               nxt_jit_up;

  // offset runs 0..2*span, so the period sweeps around the nominal value
  assign period_len = PERIOD_CYC - JITTER_SPAN_CYC + jit_ff;
  assign duty_prod  = (PER_W+7)'(period_len) * (PER_W+7)'(MAX_DUTY_PCT);
  assign max_on     = PER_W'(duty_prod / (PER_W+7)'(PCT_FULL));
  assign wrap       = (cnt_ff == period_len - 10'h001);

  // ----------------------------------------------------------------
  // triangle stepping, one step per period
  // ----------------------------------------------------------------
  // while held the offset parks at nominal so foldback sees a clean period
  assign nxt_jit_up = i_jitter_hold ? 1'b1 :
                      (jit_up_ff && (jit_ff == (JITTER_SPAN_CYC << 1) - 10'h001)) ? 1'b0 :
                      (!jit_up_ff && (jit_ff == 10'h001)) ? 1'b1 : jit_up_ff;
  assign nxt_jit    = i_jitter_hold ? JITTER_SPAN_CYC :
                      jit_up_ff ? jit_ff + 10'h001 : jit_ff - 10'h001;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff    <= '0;
      jit_ff    <= JITTER_SPAN_CYC;
      jit_up_ff <= 1'b1;
    end else begin
      cnt_ff <= wrap ? '0 : cnt_ff + 10'h001;
      if (wrap) begin
        jit_ff    <= nxt_jit;
        jit_up_ff <= nxt_jit_up;
      end
    end
  end

  assign o_period_start = (cnt_ff == '0);
  assign o_max_duty     = (cnt_ff >= max_on);

endmodule // fpfc_jitter_osc
`default_nettype wire

/* verilog/fpfc_pwm_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module fpfc_pwm_ctrl
  import fpfc_pkg::*;
#(
  parameter int unsigned SS_CYC_P      = SS_CYC,
  parameter int unsigned FAULT_CYC_P   = FAULT_CYC,
  parameter int unsigned AUTOREC_CYC_P = AUTOREC_CYC,
  parameter int unsigned WD_CYC_P      = WD_CYC,
  parameter bit          LATCHED_P     = 1'b0
)(
  // clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // current sense comparators
  input  wire logic               i_cs_above_fb_setpoint,
  input  wire logic               i_cs_above_soft_start,
  input  wire logic               i_cs_above_peak_limit,
  input  wire logic               i_cs_above_winding_short,
  // feedback comparators
  input  wire logic               i_fb_at_peak_limit,
  input  wire logic               i_fb_above_opc_level,
  input  wire logic               i_fb_light_load,
  // line and supply comparators
  input  wire logic               i_line_bo_cross,
  input  wire logic               i_brown_out,
  input  wire logic               i_supply_start,
  input  wire logic               i_supply_low,
  input  wire logic               i_supply_reset,
  // gate drive
  output logic                    o_gate_drive_out,
  // analog front end controls
  output logic [SS_W-1:0]         o_soft_start_code,
  output logic [SLOPE_W-1:0]      o_slope_comp_uv,
  output logic                    o_overpower_comp_en,
  output logic                    o_peak_sample,
  output logic                    o_peak_reset,
  // status
  output logic                    o_protect,
  output logic                    o_overload_timer_run
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int unsigned SS_STEP_RAW = SS_CYC_P / 32'(SS_CODE_MAX);
  localparam int unsigned SS_STEP_CYC = (SS_STEP_RAW == 0) ? 1 : SS_STEP_RAW;

  fpfc_state_t        state_ff;
  fpfc_state_t        nxt_state;
  logic               drive_ff;
  logic [LEB_W-1:0]   leb_cnt_ff;
  logic [SS_W-1:0]    ss_code_ff;
  logic [TMR_W-1:0]   ss_div_ff;
  logic [SLOPE_W-1:0] slope_ff;
  logic               maxd_flag_ff;
  logic [TMR_W-1:0]   ovl_cnt_ff;
  logic [TMR_W-1:0]   ar_cnt_ff;
  logic [TMR_W-1:0]   wd_cnt_ff;
  logic               bo_cross_d_ff;
  logic               sample_ff;
  logic               reset_ff;
  logic               opc_en_ff;

  logic               period_start;
  logic               max_duty;
  logic               running;
  logic               protecting;
  logic               blanked;
  logic               trip_fb;
  logic               trip_ss;
  logic               trip_peak;
  logic               trip_short;
  logic               cur_term;
  logic               maxd_term;
  logic               ss_done;
  logic               ss_tick;
  logic               setpoint_at_peak;
  logic               ovl_active;
  logic               ovl_expired;
  logic               fault;
  logic               start_ok;
  logic               release_latch;
  logic               ar_done;
  logic               bo_rise;
  logic               wd_expired;
  logic               sample_evt;
  logic               nxt_drive;
  logic               pulse_begin;
  logic [SLOPE_W-1:0] slope_sum;

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  fpfc_jitter_osc u_osc (
    .i_clk          (i_clk),
    .i_rst          (i_rst),
    .i_jitter_hold  (i_fb_light_load),
    .o_period_start (period_start),
    .o_max_duty     (max_duty)
  );

  // ----------------------------------------------------------------
  // turn-off decode
  // ----------------------------------------------------------------
  assign running    = (state_ff == ST_RUN);
  assign protecting = (state_ff == ST_PROT);
  // comparators are blind right after turn-on to skip the switching spike
  assign blanked    = (leb_cnt_ff != '0);
  assign trip_fb    = i_cs_above_fb_setpoint & ~blanked;
  assign trip_ss    = i_cs_above_soft_start & ~blanked;
  assign trip_peak  = i_cs_above_peak_limit & ~blanked;
  assign trip_short = i_cs_above_winding_short & ~blanked & drive_ff;
  assign cur_term   = drive_ff & (trip_fb | trip_ss | trip_peak);
  assign maxd_term  = drive_ff & max_duty & ~cur_term;

  // ----------------------------------------------------------------
  // overload timer and fault decode
  // ----------------------------------------------------------------
  assign ss_done          = (ss_code_ff == SS_CODE_MAX);
  // during soft-start the ramp is the lower setpoint, so peak is not yet reached
  assign setpoint_at_peak = i_fb_at_peak_limit & ss_done;
  assign ovl_active       = running & (setpoint_at_peak | maxd_flag_ff | maxd_term);
  assign ovl_expired      = ovl_active & (ovl_cnt_ff >= FAULT_CYC_P - 1);
  assign fault            = running & (trip_short | ovl_expired |
                                       (ovl_active & i_supply_low));

  // ----------------------------------------------------------------
  // state sequencing
  // ----------------------------------------------------------------
  assign start_ok      = i_supply_start & ~i_brown_out;
  assign release_latch = i_brown_out | i_supply_reset;
  assign ar_done       = (ar_cnt_ff >= AUTOREC_CYC_P - 1);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF: begin
        if (start_ok) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fault) begin
          nxt_state = ST_PROT;
        end
      end
      ST_PROT: begin
        if (LATCHED_P) begin
          if (release_latch) begin
            nxt_state = ST_OFF;
          end
        end else if (ar_done || i_supply_reset) begin
          nxt_state = ST_OFF;
        end
      end
      default: begin
        nxt_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // gate drive pulse
  // ----------------------------------------------------------------
  assign pulse_begin = running & ~fault & ~drive_ff & period_start & ~max_duty;
  assign nxt_drive   = running & ~fault &
                       (drive_ff ? ~(cur_term | maxd_term) : pulse_begin);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_ff   <= 1'b0;
      leb_cnt_ff <= '0;
    end else begin
      drive_ff   <= nxt_drive;
      leb_cnt_ff <= pulse_begin ? LEB_W'(LEB_CYC) :
                    blanked     ? leb_cnt_ff - 5'h01 : leb_cnt_ff;
    end
  end

  // ----------------------------------------------------------------
  // soft-start ramp
  // ----------------------------------------------------------------
  assign ss_tick = (ss_div_ff >= SS_STEP_CYC - 1);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ss_code_ff <= '0;
      ss_div_ff  <= '0;
    end else if (!running) begin
      ss_code_ff <= '0;
      ss_div_ff  <= '0;
    end else if (!ss_done) begin
      ss_div_ff  <= ss_tick ? '0 : ss_div_ff + 32'h0000_0001;
      ss_code_ff <= ss_tick ? ss_code_ff + 10'h001 : ss_code_ff;
    end
  end

  // ----------------------------------------------------------------
  // slope compensation, grows through each on-time
  // ----------------------------------------------------------------
  // saturates instead of wrapping so a long pulse never lifts the setpoint
  assign slope_sum = slope_ff + SLOPE_W'(SLOPE_UV_PER_CYC);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      slope_ff <= '0;
    end else if (!drive_ff) begin
      slope_ff <= '0;
    end else if (slope_sum > slope_ff) begin
      slope_ff <= slope_sum;
    end
  end

  // ----------------------------------------------------------------
  // overload timer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      maxd_flag_ff <= 1'b0;
      ovl_cnt_ff   <= '0;
    end else begin
      // a max-duty end sets the flag; a current end clears it, clear wins
      if (!running) begin
        maxd_flag_ff <= 1'b0;
      end else if (maxd_term) begin
        maxd_flag_ff <= 1'b1;
      end else if (cur_term) begin
        maxd_flag_ff <= 1'b0;
      end
      if (ovl_active) begin
        ovl_cnt_ff <= ovl_cnt_ff + 32'h0000_0001;
      end else begin
        ovl_cnt_ff <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // autorecovery delay
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ar_cnt_ff <= '0;
    end else if (protecting && !LATCHED_P) begin
      ar_cnt_ff <= ar_cnt_ff + 32'h0000_0001;
    end else begin
      ar_cnt_ff <= '0;
    end
  end

  // ----------------------------------------------------------------
  // line peak detector sampling and overpower enable
  // ----------------------------------------------------------------
  // the first value after start may be stale for one sampling cycle
  assign bo_rise    = i_line_bo_cross & ~bo_cross_d_ff;
  assign wd_expired = (wd_cnt_ff >= WD_CYC_P - 1);
  assign sample_evt = bo_rise | wd_expired;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bo_cross_d_ff <= 1'b0;
      wd_cnt_ff     <= '0;
      sample_ff     <= 1'b0;
      reset_ff      <= 1'b0;
      opc_en_ff     <= 1'b0;
    end else begin
      bo_cross_d_ff <= i_line_bo_cross;
      wd_cnt_ff     <= sample_evt ? '0 : wd_cnt_ff + 32'h0000_0001;
      sample_ff     <= sample_evt;
      reset_ff      <= sample_ff;
      opc_en_ff     <= running & i_fb_above_opc_level;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_gate_drive_out     = drive_ff;
  assign o_soft_start_code    = ss_code_ff;
  assign o_slope_comp_uv      = slope_ff;
  assign o_overpower_comp_en  = opc_en_ff;
  assign o_peak_sample        = sample_ff;
  assign o_peak_reset         = reset_ff;
  assign o_protect            = protecting;
  assign o_overload_timer_run = ovl_active;

endmodule // fpfc_pwm_ctrl
`default_nettype wire

/* verif/fpfc_pwm_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module fpfc_pwm_chk
  import fpfc_pkg::*;
#(
  parameter int unsigned FAULT_CYC_P = FAULT_CYC,
  parameter int unsigned WD_CYC_P    = WD_CYC
)(
  // clock and reset
  input wire logic               i_clk,
  input wire logic               i_rst,
  // comparator inputs
  input wire logic               i_cs_above_fb_setpoint,
  input wire logic               i_cs_above_soft_start,
  input wire logic               i_cs_above_peak_limit,
  input wire logic               i_cs_above_winding_short,
  input wire logic               i_fb_above_opc_level,
  input wire logic               i_line_bo_cross,
  input wire logic               i_supply_low,
  // outputs
  input wire logic               o_gate_drive_out,
  input wire logic [SLOPE_W-1:0] o_slope_comp_uv,
  input wire logic               o_overpower_comp_en,
  input wire logic               o_peak_sample,
  input wire logic               o_peak_reset,
  input wire logic               o_protect,
  input wire logic               o_overload_timer_run
);
  // ----------
  // helper counters
  // ----------
  logic [9:0]  on_ff;
  logic [31:0] ovl_ff;
  logic [31:0] wd_ff;
  logic        trip;
  // any of the three current comparisons ends the pulse; they are or'ed upstream too
  assign trip = i_cs_above_fb_setpoint | i_cs_above_soft_start | i_cs_above_peak_limit;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_ff  <= 10'h000;
      ovl_ff <= 32'h0000_0000;
      wd_ff  <= 32'h0000_0000;
    end else begin
      on_ff  <= o_gate_drive_out ? on_ff + 10'h001 : 10'h000;
      ovl_ff <= o_overload_timer_run ? ovl_ff + 32'h0000_0001 : 32'h0000_0000;
      wd_ff  <= o_peak_sample ? 32'h0000_0000 : wd_ff + 32'h0000_0001;
    end
  end
  // ----------
  // properties
  // ----------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  AST_BLANK: assert property ($rose(o_gate_drive_out)
    |=> (o_gate_drive_out | o_protect) [*8])
    else $error("pulse ended inside blanking");
  AST_TRIP: assert property (o_gate_drive_out && on_ff >= LEB_CYC && trip
    |=> !o_gate_drive_out)
    else $error("pulse not ended by sense trip");
  AST_MAXDUTY: assert property (o_gate_drive_out |-> on_ff < 10'h27A)
    else $error("pulse beyond max duty");
  AST_WSHORT: assert property (o_gate_drive_out && on_ff >= LEB_CYC
    && i_cs_above_winding_short |=> o_protect)
    else $error("winding short not protected");
  AST_SLOPE: assert property (o_gate_drive_out && $past(o_gate_drive_out)
    |-> o_slope_comp_uv == $past(o_slope_comp_uv) + 20'h0_028A)
    else $error("slope step wrong");
  AST_OPC: assert property (o_overpower_comp_en |-> $past(i_fb_above_opc_level))
    else $error("opc enabled at light load");
  AST_LINE: assert property ($rose(i_line_bo_cross)
    |=> o_peak_sample ##1 o_peak_reset)
    else $error("line event not sampled");
  AST_WDOG: assert property (wd_ff <= WD_CYC_P + 2)
    else $error("watchdog sample missing");
  AST_OVL: assert property (ovl_ff <= FAULT_CYC_P)
    else $error("overload timer overran");
  AST_SUPLOW: assert property (o_overload_timer_run && i_supply_low |=> o_protect)
    else $error("supply low not protected");
  cover property ($rose(o_protect));
  cover property ($fell(o_overload_timer_run) && !o_protect);
  cover property (o_peak_sample ##1 o_peak_reset);
endmodule // fpfc_pwm_chk
bind fpfc_pwm_ctrl fpfc_pwm_chk #(.FAULT_CYC_P(FAULT_CYC_P), .WD_CYC_P(WD_CYC_P)) u_chk (.*);
`default_nettype wire

/* verif/fpfc_sw_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fpfc_sw_model
  import fpfc_pkg::*;
(
  // clock and gate
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_gate,
  // levels in ramp steps
  input  wire logic [SS_W-1:0] i_ss_code,
  input  wire logic [11:0]     i_fb_lvl,
  input  wire logic [11:0]     i_pk_lvl,
  input  wire logic [11:0]     i_ws_lvl,
  // comparator flags
  output logic                 o_cs_fb,
  output logic                 o_cs_ss,
  output logic                 o_cs_pk,
  output logic                 o_cs_ws
);
  // switch current ramps while on and is zero when off, as in discontinuous mode
  logic [11:0] amp_ff;
  logic [21:0] ss_lvl;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) amp_ff <= 12'h000;
    else amp_ff <= i_gate ? amp_ff + 12'h001 : 12'h000;
  end
  // flags come from the registered ramp and the level inputs, so they change just after the edge
  assign ss_lvl  = (i_pk_lvl * i_ss_code) / 22'h00_03FF;
  assign o_cs_fb = amp_ff > i_fb_lvl;
  assign o_cs_ss = {10'h000, amp_ff} > ss_lvl;
  assign o_cs_pk = amp_ff > i_pk_lvl;
  assign o_cs_ws = amp_ff > i_ws_lvl;
endmodule // fpfc_sw_model
`default_nettype wire

/* verif/tb_flyback_pwm_fault_control.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_flyback_pwm_fault_control;
  import fpfc_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        sup_st, sup_lo, fb_pk, fb_opc, light, bo_x, bo_lvl, sup_rst;
  logic        cs_fb, cs_ss, cs_pk, cs_ws, drv, opc, smp, prst, prot, ovl;
  logic [9:0]  ss;
  logic [11:0] fb_lvl, pk_lvl, ws_lvl;
  int          miscompares = 0;
  int          checks = 0;
  int          g, w, n;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  fpfc_pwm_ctrl #(.SS_CYC_P(2046), .FAULT_CYC_P(200), .AUTOREC_CYC_P(100), .WD_CYC_P(500)) dut (
    .i_clk(clk), .i_rst(rst), .i_cs_above_fb_setpoint(cs_fb), .i_cs_above_soft_start(cs_ss),
    .i_cs_above_peak_limit(cs_pk), .i_cs_above_winding_short(cs_ws), .i_fb_at_peak_limit(fb_pk),
    .i_fb_above_opc_level(fb_opc), .i_fb_light_load(light), .i_line_bo_cross(bo_x),
    .i_brown_out(bo_lvl), .i_supply_start(sup_st), .i_supply_low(sup_lo), .i_supply_reset(sup_rst),
    .o_gate_drive_out(drv), .o_soft_start_code(ss), .o_slope_comp_uv(), .o_overpower_comp_en(opc),
    .o_peak_sample(smp), .o_peak_reset(prst), .o_protect(prot), .o_overload_timer_run(ovl));
  fpfc_sw_model sw (.i_clk(clk), .i_rst(rst), .i_gate(drv), .i_ss_code(ss), .i_fb_lvl(fb_lvl),
    .i_pk_lvl(pk_lvl), .i_ws_lvl(ws_lvl), .o_cs_fb(cs_fb), .o_cs_ss(cs_ss), .o_cs_pk(cs_pk),
    .o_cs_ws(cs_ws));
  // ----------
  // shared tasks
  // ----------
  task automatic tally_and_finish();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
    checks++;
    if (v !== e) begin
      miscompares++;
      $display("mismatch %s exp %0d got %0d", s, e, v);
    end
  endtask
  task automatic chk_in(input string s, input int lo, input int hi, input int v);
    checks++;
    if (v < lo || v > hi) begin
      miscompares++;
      $display("mismatch %s exp %0d..%0d got %0d", s, lo, hi, v);
    end
  endtask
  // a bound that runs out is a mismatch and ends the run
  task automatic wait_on(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v) begin
      if (++n > lim) begin
        chk("wait bound", 1'b1, 1'b0);
        tally_and_finish();
      end
      step(1);
    end
  endtask
  // rise-to-rise period is width plus the following gap
  task automatic pulse(output int gp, output int wd);
    wait_on(drv, 1'b1, 5000);
    gp = n;
    wait_on(drv, 1'b0, 5000);
    wd = n;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_soft_start();
    int w0;
    sup_st = 1'b1;
    pulse(g, w0);
    pulse(g, w);
    chk("ramp width grows", 1'b1, w > w0);
    n = 0;
    while (ss !== SS_CODE_MAX) begin
      if (++n > 3000) begin
        chk("ramp top", SS_CODE_MAX, ss);
        tally_and_finish();
      end
      step(1);
    end
    pulse(g, w);
    pulse(g, w);
    chk("peak limit width", 32'h0000_012E, w);
    fb_lvl = 12'h062;
    pulse(g, w);
    pulse(g, w);
    chk("feedback width", 32'h0000_0064, w);
    $display("soft start and trip done");
  endtask
  task automatic t_jitter();
    int p0, p1, wp;
    pulse(g, wp);
    p0 = 0;
    repeat (9) begin
      pulse(g, w);
      p1 = wp + g;
      wp = w;
      chk_in("period", PERIOD_CYC - JITTER_SPAN_CYC, PERIOD_CYC + JITTER_SPAN_CYC, p1);
      if (p0 != 0) chk_in("period step", 1, 1, p1 > p0 ? p1 - p0 : p0 - p1);
      p0 = p1;
    end
    light = 1'b1;
    repeat (4) begin
      pulse(g, w);
      p1 = wp + g;
      wp = w;
    end
    chk("held period", PERIOD_CYC, p1);
    light = 1'b0;
    $display("jitter done");
  endtask
  task automatic t_line();
    fb_opc = 1'b1;
    step(2);
    chk("opc on", 1'b1, opc);
    fb_opc = 1'b0;
    step(2);
    chk("opc off", 1'b0, opc);
    bo_x = 1'b1;
    wait_on(smp, 1'b1, 4);
    step(1);
    chk("peak reset", 1'b1, prst);
    bo_x = 1'b0;
    g = 0;
    repeat (1100) begin
      step(1);
      if (smp === 1'b1) g++;
    end
    chk_in("watchdog samples", 2, 3, g);
    $display("line sampling done");
  endtask
  task automatic t_overload();
    fb_pk = 1'b1;
    step(150);
    chk("timer runs", 1'b1, ovl);
    fb_pk = 1'b0;
    step(2);
    chk("timer idle", 1'b0, ovl);
    fb_pk = 1'b1;
    step(150);
    chk("no fault", 1'b0, prot);
    sup_lo = 1'b1;
    step(2);
    chk("supply low fault", 1'b1, prot);
    sup_lo = 1'b0;
    fb_pk = 1'b0;
    wait_on(prot, 1'b0, 500);
    chk_in("restart delay", 97, 102, n);
    $display("overload done");
  endtask
  task automatic t_max_duty();
    fb_lvl = 12'hFA0;
    pk_lvl = 12'hFA0;
    wait_on(prot, 1'b1, 2000);
    wait_on(prot, 1'b0, 500);
    pulse(g, w);
    chk_in("max duty width", 595, 634, w);
    wait_on(prot, 1'b1, 300);
    chk("max duty fault", 1'b1, prot);
    ws_lvl = 12'h00C;
    wait_on(prot, 1'b0, 500);
    pulse(g, w);
    chk("short width", LEB_CYC + 1, w);
    chk("short fault", 1'b1, prot);
    sup_rst = 1'b1;
    step(1);
    chk("supply reset exit", 1'b0, prot);
    sup_rst = 1'b0;
    bo_lvl = 1'b1;
    step(4);
    chk("brown-out holds off", 10'h000, ss);
    bo_lvl = 1'b0;
    step(4);
    chk("restart ramp", 10'h001, ss);
    $display("max duty and short done");
  endtask
  initial begin
    {sup_st, sup_lo, fb_pk, fb_opc, light, bo_x, bo_lvl, sup_rst} = 8'h00;
    fb_lvl = 12'hFA0;
    pk_lvl = 12'h12C;
    ws_lvl = 12'hFFF;
    step(10);
    chk("drive in reset", 1'b0, drv);
    chk("protect in reset", 1'b0, prot);
    rst = 1'b0;
    t_soft_start();
    t_jitter();
    t_line();
    t_overload();
    t_max_duty();
    tally_and_finish();
  end
endmodule // tb_flyback_pwm_fault_control
`default_nettype wire
